/* core/icrp_config_port.sv */
// Index and data port front end for the configuration registers
module icrp_config_port
    import icrp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        io_req,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic             io_done,
    output logic             ext_req,
    output logic [7:0]       io_rdata,
    output logic [7:0]       cache_power_control_a,
    output logic [7:0]       cache_power_control_b,
    output logic [23:0]      uncached_region_one,
    output logic [23:0]      uncached_region_two,
    output logic [23:0]      uncached_region_three,
    output logic [23:0]      uncached_region_four
);
    logic [7:0]  idx;
    logic        idx_valid;
    logic [7:0]  next_rdata;
    logic [23:0] region_value [REGION_COUNT];
    logic        is_index;
    logic        is_data;
    logic        in_range;
    logic        take_index;
    logic        data_hit;
    logic        data_wr;
    logic        internal;

    assign is_index   = (io_addr == PORT_INDEX);
    assign is_data    = (io_addr == PORT_DATA);
    assign in_range   = (io_wdata >= IDX_LO) && (io_wdata <= IDX_HI);
    assign take_index = io_req && io_write && is_index && in_range;
    // Data port only hits while an index is armed
    assign data_hit   = io_req && is_data && idx_valid;
    assign data_wr    = data_hit && io_write;
    assign internal   = take_index || data_hit;

    // Index capture and arming
    // Reads of the index port are not decoded and go off-chip
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            idx       <= 8'h00;
            idx_valid <= 1'b0;
        end
        else if (io_req && io_write && is_index)
        begin
            idx       <= io_wdata;
            idx_valid <= in_range;
        end
        // One data access per index write
        else if (io_req && is_data)
            idx_valid <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            io_done <= 1'b0;
            ext_req <= 1'b0;
        end
        else
        begin
            io_done <= internal;
            ext_req <= io_req && !internal;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cache_power_control_a <= CPC_RESET;
            cache_power_control_b <= CPC_RESET;
        end
        else if (data_wr && idx == IDX_CPC_A)
            cache_power_control_a <= io_wdata;
        else if (data_wr && idx == IDX_CPC_B)
            cache_power_control_b <= io_wdata;
    end

    for (genvar g = 0; g < REGION_COUNT; g++)
    begin : gen_region
        icrp_reg_if regbus ();
        assign regbus.wr_en    = data_wr && (idx >= REGION_BASE[g]) && (idx <= 8'(REGION_BASE[g] + REGION_SPAN));
        assign regbus.byte_sel = 2'(idx - REGION_BASE[g]);
        assign regbus.wdata    = io_wdata;
        assign region_value[g] = regbus.value;
        // Only region one starts at full size
        icrp_region_reg #(
            .RESET_VALUE (g == 0 ? REGION_ONE_RESET : REGION_ZERO_RESET)
        ) u_region (
            .sys_clk (sys_clk),
            .reset   (reset),
            .bus     (regbus)
        );
    end

    assign uncached_region_one   = region_value[0];
    assign uncached_region_two   = region_value[1];
    assign uncached_region_three = region_value[2];
    assign uncached_region_four  = region_value[3];

    always_comb
    begin
        next_rdata = 8'h00;
        if (idx == IDX_CPC_A)
            next_rdata = cache_power_control_a;
        else if (idx == IDX_CPC_B)
            next_rdata = cache_power_control_b;
        for (int k = 0; k < REGION_COUNT; k++)
        begin
            if (idx == REGION_BASE[k])
                next_rdata = region_value[k][23:16];
            else if (idx == 8'(REGION_BASE[k] + 8'h01))
                next_rdata = region_value[k][15:8];
            else if (idx == 8'(REGION_BASE[k] + REGION_SPAN))
                next_rdata = region_value[k][7:0];
        end
    end

    // Read data held until the next internal read
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            io_rdata <= 8'h00;
        else if (data_hit && !io_write)
            io_rdata <= next_rdata;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_index_ok;
        io_req && io_write && is_index && in_range;
    endsequence
    sequence seq_index_bad;
        io_req && io_write && is_index && !in_range;
    endsequence
    sequence seq_data_armed;
        io_req && is_data && idx_valid;
    endsequence
    sequence seq_read_armed;
        io_req && is_data && idx_valid && !io_write;
    endsequence
    sequence seq_write_armed;
        io_req && is_data && idx_valid && io_write;
    endsequence
    sequence seq_data_unarmed;
        io_req && is_data && !idx_valid;
    endsequence
    sequence seq_index_read;
        io_req && !io_write && is_index;
    endsequence

    chk_index_accept: assert property (seq_index_ok |=> idx_valid && io_done && !ext_req)
        else $error("in-range index write not taken internally");
    chk_data_internal: assert property (seq_data_armed |=> io_done && !ext_req && !idx_valid)
        else $error("armed data access did not complete internally");
    chk_no_ext_hit: assert property (io_done |-> !ext_req)
        else $error("internal hit also started an external cycle");
    chk_second_data_ext: assert property (seq_data_armed ##1 (io_req && is_data) |=> ext_req && !io_done)
        else $error("second data access stayed internal");
    chk_range_forward: assert property (seq_index_bad |=> ext_req && !idx_valid
        && $stable(cache_power_control_a) && $stable(uncached_region_one))
        else $error("out-of-range index not forwarded or changed a register");
    chk_ctrl_readback: assert property (seq_read_armed ##0 (idx == IDX_CPC_A)
        |=> io_rdata == $past(cache_power_control_a))
        else $error("control register readback wrong");
    chk_reset_values: assert property (disable iff (1'b0) $fell(reset) |->
        uncached_region_one == REGION_ONE_RESET && cache_power_control_b == CPC_RESET && !idx_valid)
        else $error("reset values wrong");
    chk_region_top_byte: assert property (seq_write_armed ##0 (idx == IDX_LO + 8'h04)
        |=> uncached_region_one[23:16] == $past(io_wdata) && $stable(uncached_region_one[15:0]))
        else $error("region first byte not written to high lane");
    chk_reserved_read: assert property (seq_read_armed ##0 (idx inside {8'hC2, 8'hC3})
        |=> io_rdata == 8'h00 && io_done)
        else $error("reserved index read not zero");

    // Every cycle answered once, and only when asked
    chk_idle_quiet: assert property (!io_req |=> !io_done && !ext_req)
        else $error("answer without a request");
    chk_unarmed_data: assert property (seq_data_unarmed |=> ext_req && !io_done && $stable(io_rdata))
        else $error("unarmed data access not forwarded");
    chk_index_read_ext: assert property (seq_index_read |=> ext_req && !io_done && $stable(idx_valid))
        else $error("index port read not forwarded or changed arming");
    chk_index_replace: assert property (seq_index_ok |=> idx == $past(io_wdata))
        else $error("index write did not replace the index");
    chk_ctrl_a_write: assert property (seq_write_armed ##0 (idx == IDX_CPC_A)
        |=> cache_power_control_a == $past(io_wdata) && $stable(cache_power_control_b))
        else $error("control register a write lost");
    chk_ctrl_b_write: assert property (seq_write_armed ##0 (idx == IDX_CPC_B)
        |=> cache_power_control_b == $past(io_wdata) && $stable(cache_power_control_a))
        else $error("control register b write lost");
    chk_region_mid_byte: assert property (seq_write_armed ##0 (idx == 8'(REGION_BASE[0] + 8'h01))
        |=> uncached_region_one[15:8] == $past(io_wdata) && $stable(uncached_region_one[23:16]))
        else $error("region middle byte not written to middle lane");
    chk_region_two_top: assert property (seq_write_armed ##0 (idx == REGION_BASE[1])
        |=> uncached_region_two[23:16] == $past(io_wdata) && $stable(uncached_region_one))
        else $error("second region first byte misplaced");
    chk_region_three_low: assert property (seq_write_armed ##0 (idx == 8'(REGION_BASE[2] + REGION_SPAN))
        |=> uncached_region_three[7:0] == $past(io_wdata) && $stable(uncached_region_three[23:8]))
        else $error("third region last byte misplaced");
    chk_region_low_byte: assert property (seq_write_armed ##0 (idx == IDX_HI)
        |=> uncached_region_four[7:0] == $past(io_wdata) && $stable(uncached_region_four[23:8]))
        else $error("last region third byte not written to low lane");
    chk_region_read_back: assert property (seq_read_armed ##0 (idx == 8'(REGION_BASE[3] + 8'h01))
        |=> io_rdata == $past(uncached_region_four[15:8]))
        else $error("region readback wrong");
    chk_reserved_write: assert property (seq_write_armed ##0 (idx inside {8'hC2, 8'hC3})
        |=> io_done && $stable(cache_power_control_a) && $stable(cache_power_control_b)
        && $stable(uncached_region_one) && $stable(uncached_region_two))
        else $error("reserved index write changed a register");
    // Out-of-range index must spare the registers the first range check leaves out
    chk_range_spares: assert property (seq_index_bad |=> $stable(cache_power_control_b)
        && $stable(uncached_region_two) && $stable(uncached_region_three) && $stable(uncached_region_four))
        else $error("out-of-range index changed a register");
endmodule : icrp_config_port

/* core/icrp_pkg.sv */
// Constants for the indexed configuration register port
package icrp_pkg;
    localparam logic [15:0] PORT_INDEX        = 16'h0022;
    localparam logic [15:0] PORT_DATA         = 16'h0023;
    localparam logic [7:0]  IDX_LO            = 8'hC0;
    localparam logic [7:0]  IDX_HI            = 8'hCF;
    localparam logic [7:0]  IDX_CPC_A         = 8'hC0;
    localparam logic [7:0]  IDX_CPC_B         = 8'hC1;
    localparam logic [7:0]  REGION_SPAN       = 8'h02;
    localparam int          REGION_COUNT      = 4;
    localparam logic [7:0]  REGION_BASE [4]   = '{8'hC4, 8'hC7, 8'hCA, 8'hCD};
    localparam logic [7:0]  CPC_RESET         = 8'h00;
    localparam logic [23:0] REGION_ZERO_RESET = 24'h000000;
    localparam logic [23:0] REGION_ONE_RESET  = 24'h00000F;
endpackage : icrp_pkg

/* core/icrp_reg_if.sv */
// Write and readback bundle for one region register
interface icrp_reg_if;
    logic        wr_en;
    logic [1:0]  byte_sel;
    logic [7:0]  wdata;
    logic [23:0] value;
    modport store (input wr_en, input byte_sel, input wdata, output value);
    modport ctrl  (output wr_en, output byte_sel, output wdata, input value);
endinterface : icrp_reg_if

/* core/icrp_region_reg.sv */
// One 24-bit region register written a byte at a time
module icrp_region_reg
    import icrp_pkg::*;
#(
    parameter logic [23:0] RESET_VALUE = REGION_ZERO_RESET
)
(
    input wire logic   sys_clk,
    input wire logic   reset,
    icrp_reg_if.store  bus
);
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            bus.value <= RESET_VALUE;
        else if (bus.wr_en)
        begin
            case (bus.byte_sel)
                2'h0:    bus.value[23:16] <= bus.wdata;
                2'h1:    bus.value[15:8]  <= bus.wdata;
                default: bus.value[7:0]   <= bus.wdata;
            endcase
        end
    end
endmodule : icrp_region_reg

/* tb/icrp_core_model.sv */
// Core-side model that issues I/O cycles to the port
module icrp_core_model
(
    input  wire logic        sys_clk,
    output logic             io_req,
    output logic             io_write,
    output logic [15:0]      io_addr,
    output logic [7:0]       io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        io_req = 1'b0;
        io_write = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end
    task automatic issue(input logic wr, input logic [15:0] a, input logic [7:0] d);
        io_req = 1'b1;
        io_write = wr;
        io_addr = a;
        io_wdata = d;
        @(negedge sys_clk);
    endtask : issue
    // Released address and data lines show no stale value
    task automatic idle;
        io_req = 1'b0;
        io_addr = ~io_addr;
        io_wdata = ~io_wdata;
        @(negedge sys_clk);
    endtask : idle
endmodule : icrp_core_model

/* tb/testbench.sv */
// Self-checking bench for the indexed configuration register port
module testbench import icrp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic ok; logic [7:0] rd; } icrp_note_t;
    logic        sys_clk;
    logic        reset;
    logic        io_req;
    logic        io_write;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic        io_done;
    logic        ext_req;
    logic [7:0]  io_rdata;
    logic [7:0]  cpc_a;
    logic [7:0]  cpc_b;
    logic [23:0] region [4];
    logic [7:0]  mirror [16];
    logic [7:0]  idx;
    logic        armed;
    logic [7:0]  last_rd;
    logic [31:0] seed = 32'h00000013;
    logic [31:0] r;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    icrp_note_t  note;
    icrp_note_t  notes [$];
    icrp_core_model cpu (.sys_clk(sys_clk), .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
        .io_wdata(io_wdata));
    icrp_config_port DUT (.sys_clk(sys_clk), .reset(reset), .io_req(io_req), .io_write(io_write),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_done(io_done), .ext_req(ext_req), .io_rdata(io_rdata),
        .cache_power_control_a(cpc_a), .cache_power_control_b(cpc_b), .uncached_region_one(region[0]),
        .uncached_region_two(region[1]), .uncached_region_three(region[2]), .uncached_region_four(region[3]));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic model_reset;
        foreach (mirror[i]) mirror[i] = 8'h00;
        mirror[6] = 8'h0F;
        armed = 1'b0;
        last_rd = 8'h00;
    endtask : model_reset
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        logic ok;
        ok = (a == PORT_INDEX && wr && d >= IDX_LO && d <= IDX_HI) || (a == PORT_DATA && armed);
        if (a == PORT_DATA && ok && wr && idx[3:1] != 3'b001)
            mirror[idx[3:0]] = d;
        if (a == PORT_DATA && ok && !wr)
            last_rd = mirror[idx[3:0]];
        if (a == PORT_INDEX && wr)
            idx = d;
        if (a == PORT_DATA || (a == PORT_INDEX && wr))
            armed = (a == PORT_INDEX) && ok;
        notes.push_back('{ok, last_rd});
        cpu.issue(wr, a, d);
    endtask : acc
    task automatic regs;
        cpu.idle();
        repeat (3) @(negedge sys_clk);
        check(notes.size(), 0);
        check(cpc_a, mirror[0]);
        check(cpc_b, mirror[1]);
        for (int k = 0; k < 4; k++)
            check(region[k], {mirror[4+3*k], mirror[5+3*k], mirror[6+3*k]});
    endtask : regs
    always @(negedge sys_clk)
    begin
        if (io_done === 1'b1 || ext_req === 1'b1)
        begin
            check(notes.size() > 0, 1);
            note = notes.pop_front();
            check({io_done, ext_req}, {note.ok, !note.ok});
            check(io_rdata, note.rd);
        end
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        reset = 1'b1;
        model_reset();
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        regs();
        $display("test reset values done");
        for (int i = 0; i < 32; i++)
        begin
            r = xs();
            acc(1'b1, PORT_INDEX, IDX_LO + i[7:0] % 8'h10);
            acc(i < 16, PORT_DATA, r[7:0]);
        end
        acc(1'b1, PORT_INDEX, 8'hBF);
        acc(1'b1, PORT_DATA, 8'hAA);
        acc(1'b1, PORT_INDEX, 8'hD0);
        acc(1'b0, PORT_INDEX, 8'h00);
        acc(1'b1, PORT_DATA, 8'h55);
        regs();
        $display("test directed done");
        for (int k = 0; k < 600; k++)
        begin
            r = xs();
            acc(r[8], r[10:9] == 2'b00 ? 16'h0021 ^ {8'h00, r[23:16]} : (r[11] ? PORT_INDEX : PORT_DATA),
                r[12] ? {4'hC, r[7:4]} : r[7:0]);
            if (r[13] && r[14])
                cpu.idle();
        end
        regs();
        $display("test random done");
        acc(1'b1, PORT_INDEX, 8'hC6);
        acc(1'b1, PORT_DATA, 8'h3C);
        acc(1'b1, PORT_INDEX, 8'hC0);
        regs();
        reset = 1'b1;
        model_reset();
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        acc(1'b0, PORT_DATA, 8'h00);
        regs();
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : testbench
